//--- hw/align_checker.sv
// alignment requirement lookup and misalignment test
// assumes data type codes from fault_pkg; purely combinational
`timescale 1ns/1ns
module align_checker (
   input  wire logic [3:0] dtype_i,
   input  wire logic [1:0] opsize_i,
   input  wire logic [3:0] addr_lo_i,
   output logic            misaligned_o
);
   // =====================================
   // required alignment minus one, as a low-bit mask
   function automatic logic [3:0] align_mask(input logic [3:0] dt, input logic [1:0] os);
      case (dt)
         fault_pkg::DT_WORD, fault_pkg::DT_SEL, fault_pkg::DT_FAR32: align_mask = 4'h1;
         fault_pkg::DT_DWORD, fault_pkg::DT_NEAR32, fault_pkg::DT_FAR48: align_mask = 4'h3;
         fault_pkg::DT_QWORD, fault_pkg::DT_M64: align_mask = 4'h7;
         fault_pkg::DT_M128, fault_pkg::DT_M256: align_mask = 4'hF;
         // bit strings: 0=word 1=dword else qword
         fault_pkg::DT_BITSTR: align_mask = (os == 2'h0) ? 4'h1 : (os == 2'h1) ? 4'h3 : 4'h7;
         default: align_mask = 4'h0;
      endcase
   endfunction : align_mask

   assign misaligned_o = |(addr_lo_i & align_mask(dtype_i, opsize_i));
endmodule : align_checker

//--- hw/fault_condition_detector.sv
// fault condition detector: raises protection, page, x87, alignment, machine-check
// and simd faults and presents one request per cycle to dispatch
// assumes pipeline condition inputs are one-cycle pulses synchronous to mclk_i
`timescale 1ns/1ns
module fault_condition_detector (
   input  wire logic        mclk_i,
   input  wire logic        rst_n_i,
   // axi4-lite slave
   input  wire logic [7:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [7:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   // pipeline state
   input  wire logic [1:0]  current_privilege_level_i,
   input  wire logic        alignment_check_flag_i,
   input  wire logic [63:0] insn_ip_i,
   // protection causes, descriptor class (selector code)
   input  wire logic        seg_priv_fail_i,
   input  wire logic        seg_type_fail_i,
   input  wire logic        null_sel_load_i,
   input  wire logic        gate_null_sel_i,
   input  wire logic        gate_bad_long_i,
   input  wire logic        task_xfer_long_i,
   input  wire logic        sysdesc_bad_long_i,
   input  wire logic [15:0] selector_i,
   // protection causes, zero code
   input  wire logic        dtr_noncanon_i,
   input  wire logic [3:0]  insn_len_i,
   input  wire logic        insn_len_over_i,
   input  wire logic        fetch_bad_i,
   input  wire logic        msr_write_bad_i,
   input  wire logic        cr_write_bad_i,
   input  wire logic        cr_set_nw_i,
   input  wire logic        cr_set_cd_i,
   input  wire logic        priv_insn_i,
   input  wire logic        media_unaligned_i,
   input  wire logic        seg_write_bad_i,
   // page translation
   input  wire logic        pf_not_present_i,
   input  wire logic        pf_nx_fetch_i,
   input  wire logic        pf_prot_fail_i,
   input  wire logic        pf_rsv_bit_i,
   input  wire logic        pf_key_fail_i,
   input  wire logic        pf_write_i,
   input  wire logic [63:0] pf_linear_addr_i,
   // x87
   input  wire logic [5:0]  x87_status_i,
   input  wire logic [5:0]  x87_mask_i,
   input  wire logic        x87_wait_insn_i,
   input  wire logic [63:0] x87_last_ip_i,
   // alignment
   input  wire logic        data_ref_i,
   input  wire logic [3:0]  data_type_i,
   input  wire logic [1:0]  data_opsize_i,
   input  wire logic [3:0]  data_addr_lo_i,
   // machine check and simd
   input  wire logic        mc_error_i,
   input  wire logic        ip_valid_flag_i,
   input  wire logic [5:0]  simd_status_i,
   input  wire logic [5:0]  simd_mask_i,
   input  wire logic        simd_event_i,
   // dispatch request
   output logic             exc_valid_o,
   output logic [7:0]       exc_vector_o,
   output logic             exc_code_valid_o,
   output logic [31:0]      exc_code_o,
   output logic [63:0]      exc_ip_o,
   output logic             exc_ip_valid_o
);
   // =====================================
   // control and state registers
   logic [6:0]  ctrl_r;
   logic [63:0] fault_address_reg_r;
   logic [63:0] x87_ip_r;
   logic [7:0]  last_vec_r;
   logic        misaligned;
   logic        long_mode;

   assign long_mode = ctrl_r[fault_pkg::CTRL_LONG];

   align_checker u_align (
      .dtype_i      (data_type_i),
      .opsize_i     (data_opsize_i),
      .addr_lo_i    (data_addr_lo_i),
      .misaligned_o (misaligned)
   );

   // =====================================
   // condition detection
   logic gp_sel, gp_zero, gp_any, pf_rsv_ok, pf_any, mf_any, ac_any, mc_any, xf_raw, xf_any;
   logic ud_any;
   always_comb begin
      gp_sel  = seg_priv_fail_i | seg_type_fail_i | null_sel_load_i | gate_null_sel_i
              | (long_mode & (gate_bad_long_i | task_xfer_long_i))
              | (long_mode & sysdesc_bad_long_i);
      gp_zero = (long_mode & dtr_noncanon_i)
              | insn_len_over_i | (insn_len_i > fault_pkg::MAX_INSN_LEN) | fetch_bad_i
              | msr_write_bad_i
              | cr_write_bad_i | (cr_set_nw_i & ~cr_set_cd_i)
              | (priv_insn_i & (current_privilege_level_i != 2'h0))
              | media_unaligned_i | seg_write_bad_i;
      gp_any  = gp_sel | gp_zero;
      pf_rsv_ok = pf_rsv_bit_i & (ctrl_r[fault_pkg::CTRL_PSE] | ctrl_r[fault_pkg::CTRL_PAE]);
      pf_any  = pf_not_present_i | pf_nx_fetch_i | pf_prot_fail_i | pf_key_fail_i | pf_rsv_ok;
      mf_any  = ctrl_r[fault_pkg::CTRL_NE] & x87_wait_insn_i
              & |(x87_status_i & ~x87_mask_i);
      ac_any  = data_ref_i & misaligned & ctrl_r[fault_pkg::CTRL_AM] & alignment_check_flag_i
              & (current_privilege_level_i == fault_pkg::CPL_USER);
      mc_any  = mc_error_i & ctrl_r[fault_pkg::CTRL_MCE];
      xf_raw  = simd_event_i & |(simd_status_i & ~simd_mask_i);
      xf_any  = xf_raw & ctrl_r[fault_pkg::CTRL_OSXF];
      ud_any  = xf_raw & ~ctrl_r[fault_pkg::CTRL_OSXF];
   end

   // =====================================
   // dispatch request, machine check first
   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         exc_valid_o      <= 1'b0;
         exc_vector_o     <= 8'h00;
         exc_code_valid_o <= 1'b0;
         exc_code_o       <= 32'h0000_0000;
         exc_ip_o         <= 64'h0;
         exc_ip_valid_o   <= 1'b0;
      end else begin
         exc_valid_o      <= mc_any | gp_any | pf_any | ac_any | mf_any | xf_any | ud_any;
         exc_code_valid_o <= 1'b0;
         exc_code_o       <= 32'h0000_0000;
         exc_ip_o         <= insn_ip_i;
         exc_ip_valid_o   <= 1'b1;
         exc_vector_o     <= 8'h00;
         if (mc_any) begin
            exc_vector_o   <= fault_pkg::VEC_MC;
            exc_ip_valid_o <= ip_valid_flag_i;
         end else if (gp_any) begin
            exc_vector_o     <= fault_pkg::VEC_GP;
            exc_code_valid_o <= 1'b1;
            exc_code_o       <= gp_sel ? {16'h0000, selector_i[15:3], 3'h0} : 32'h0;
         end else if (pf_any) begin
            exc_vector_o     <= fault_pkg::VEC_PF;
            exc_code_valid_o <= 1'b1;
            exc_code_o       <= {26'h0, pf_key_fail_i, pf_nx_fetch_i, pf_rsv_ok,
                                 (current_privilege_level_i == fault_pkg::CPL_USER),
                                 pf_write_i, ~pf_not_present_i};
         end else if (ac_any) begin
            exc_vector_o     <= fault_pkg::VEC_AC;
            exc_code_valid_o <= 1'b1;
         end else if (mf_any) begin
            exc_vector_o <= fault_pkg::VEC_MF;
         end else if (xf_any) begin
            exc_vector_o <= fault_pkg::VEC_XF;
         end else if (ud_any) begin
            exc_vector_o <= fault_pkg::VEC_UD;
         end
      end
   end

   // =====================================
   // x87 last faulting instruction pointer
   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) x87_ip_r <= 64'h0;
      else if (|(x87_status_i & ~x87_mask_i) & ~x87_wait_insn_i) x87_ip_r <= x87_last_ip_i;
   end

   // =====================================
   // axi4-lite write channel
   logic        aw_have_r, w_have_r;
   logic [7:0]  aw_addr_r;
   logic [31:0] w_data_r;
   logic [3:0]  w_strb_r;
   logic        wr_go;
   assign wr_go = aw_have_r & w_have_r & ~s_axi_bvalid;

   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         aw_have_r <= 1'b0;
         w_have_r  <= 1'b0;
         aw_addr_r <= 8'h00;
         w_data_r  <= 32'h0;
         w_strb_r  <= 4'h0;
         s_axi_bvalid <= 1'b0;
      end else begin
         if (s_axi_awvalid & s_axi_awready) begin
            aw_have_r <= 1'b1;
            aw_addr_r <= s_axi_awaddr;
         end else if (wr_go) aw_have_r <= 1'b0;
         if (s_axi_wvalid & s_axi_wready) begin
            w_have_r <= 1'b1;
            w_data_r <= s_axi_wdata;
            w_strb_r <= s_axi_wstrb;
         end else if (wr_go) w_have_r <= 1'b0;
         if (wr_go) s_axi_bvalid <= 1'b1;
         else if (s_axi_bready) s_axi_bvalid <= 1'b0;
      end
   end
   assign s_axi_awready = ~aw_have_r;
   assign s_axi_wready  = ~w_have_r;
   assign s_axi_bresp   = 2'b00;

   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] st);
      for (int i = 0; i < 4; i++) merge[i*8 +: 8] = st[i] ? nw[i*8 +: 8] : old[i*8 +: 8];
   endfunction : merge

   // =====================================
   // control register; long-mode flag fed by software
   logic [31:0] ctrl_nxt;
   assign ctrl_nxt = merge({25'h0, ctrl_r}, w_data_r, w_strb_r);
   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) ctrl_r <= fault_pkg::CTRL_RESET;
      else if (wr_go && aw_addr_r == fault_pkg::ADDR_CTRL)
         ctrl_r <= ctrl_nxt[6:0];
   end

   // =====================================
   // fault address register; a page fault not pre-empted by machine check or protection fault wins over software write
   logic [63:0] fla_sw;
   always_comb begin
      fla_sw = fault_address_reg_r;
      if (wr_go && aw_addr_r == fault_pkg::ADDR_FLA_LO)
         fla_sw[31:0] = merge(fault_address_reg_r[31:0], w_data_r, w_strb_r);
      if (wr_go && aw_addr_r == fault_pkg::ADDR_FLA_HI)
         fla_sw[63:32] = merge(fault_address_reg_r[63:32], w_data_r, w_strb_r);
   end
   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) fault_address_reg_r <= 64'h0;
      else if (pf_any & ~mc_any & ~gp_any)
         fault_address_reg_r <= long_mode ? pf_linear_addr_i
                                          : {32'h0, pf_linear_addr_i[31:0]};
      else if (wr_go)
         fault_address_reg_r <= long_mode ? fla_sw : {32'h0, fla_sw[31:0]};
   end

   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) last_vec_r <= 8'h00;
      else if (exc_valid_o) last_vec_r <= exc_vector_o;
   end

   // =====================================
   // axi4-lite read channel
   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= 32'h0;
      end else if (s_axi_arvalid & s_axi_arready) begin
         s_axi_rvalid <= 1'b1;
         case (s_axi_araddr)
            fault_pkg::ADDR_FLA_LO: s_axi_rdata <= fault_address_reg_r[31:0];
            fault_pkg::ADDR_FLA_HI: s_axi_rdata <= fault_address_reg_r[63:32];
            fault_pkg::ADDR_CTRL:   s_axi_rdata <= {25'h0, ctrl_r};
            fault_pkg::ADDR_STATUS: s_axi_rdata <= {23'h0, exc_valid_o, last_vec_r};
            fault_pkg::ADDR_FPU_IP: s_axi_rdata <= x87_ip_r[31:0];
            default:                s_axi_rdata <= fault_pkg::BUS_OKAY;
         endcase
      end else if (s_axi_rready) s_axi_rvalid <= 1'b0;
   end
   assign s_axi_arready = ~s_axi_rvalid;
   assign s_axi_rresp   = 2'b00;

   // =====================================
   // checks
   property p_ac_user_only;
      @(posedge mclk_i) disable iff (!rst_n_i)
      (ac_any) |-> (current_privilege_level_i == 2'h3 && ctrl_r[1]);
   endproperty
   a_ac_user_only: assert property (p_ac_user_only) else $error("alignment fault below user");

   property p_mf_needs_ne;
      @(posedge mclk_i) disable iff (!rst_n_i)
      (!ctrl_r[0]) |-> ##1 !(exc_valid_o && exc_vector_o == 8'h10 && !$past(ctrl_r[0]));
   endproperty
   a_mf_needs_ne: assert property (p_mf_needs_ne) else $error("x87 fault while disabled");

   property p_pf_vec;
      @(posedge mclk_i) disable iff (!rst_n_i)
      (pf_any && !mc_any && !gp_any) |=> (exc_valid_o && exc_vector_o == 8'h0E && exc_code_valid_o);
   endproperty
   a_pf_vec: assert property (p_pf_vec) else $error("page fault not presented");

   property p_pf_addr;
      @(posedge mclk_i) disable iff (!rst_n_i)
      (pf_any && !mc_any && !gp_any && long_mode) |=> fault_address_reg_r == $past(pf_linear_addr_i);
   endproperty
   a_pf_addr: assert property (p_pf_addr) else $error("fault address not captured");

   property p_legacy_hi;
      @(posedge mclk_i) disable iff (!rst_n_i)
      (!long_mode && (pf_any || wr_go)) |=> fault_address_reg_r[63:32] == 32'h0;
   endproperty
   a_legacy_hi: assert property (p_legacy_hi) else $error("upper address not cleared");

   property p_xf_ud;
      @(posedge mclk_i) disable iff (!rst_n_i)
      (xf_raw && !ctrl_r[3] && !mc_any && !gp_any && !pf_any && !ac_any && !mf_any)
         |=> exc_vector_o == 8'h06;
   endproperty
   a_xf_ud: assert property (p_xf_ud) else $error("simd without support not undefined");

   property p_gp_code;
      @(posedge mclk_i) disable iff (!rst_n_i)
      (gp_zero && !gp_sel && !mc_any) |=> (exc_vector_o == 8'h0D && exc_code_o == 32'h0);
   endproperty
   a_gp_code: assert property (p_gp_code) else $error("protection fault code not zero");

   property p_mc_nocode;
      @(posedge mclk_i) disable iff (!rst_n_i)
      (mc_any) |=> (exc_vector_o == 8'h12 && !exc_code_valid_o
                    && exc_ip_valid_o == $past(ip_valid_flag_i));
   endproperty
   a_mc_nocode: assert property (p_mc_nocode) else $error("machine check request wrong");

   property p_rsv_gate;
      @(posedge mclk_i) disable iff (!rst_n_i)
      (pf_rsv_bit_i && !ctrl_r[4] && !ctrl_r[5]) |-> !pf_rsv_ok;
   endproperty
   a_rsv_gate: assert property (p_rsv_gate) else $error("reserved bit fault while disabled");
endmodule : fault_condition_detector

//--- hw/fault_pkg.sv
// fault detector constants: vectors, register map, field positions, alignment data type codes
// assumes a single core clock domain and an axi4-lite register bus
package fault_pkg;
   // =====================================
   // vectors
   localparam logic [7:0] VEC_UD = 8'h06;
   localparam logic [7:0] VEC_GP = 8'h0D;
   localparam logic [7:0] VEC_PF = 8'h0E;
   localparam logic [7:0] VEC_MF = 8'h10;
   localparam logic [7:0] VEC_AC = 8'h11;
   localparam logic [7:0] VEC_MC = 8'h12;
   localparam logic [7:0] VEC_XF = 8'h13;
   // =====================================
   // register map (byte addresses)
   localparam logic [7:0] ADDR_FLA_LO  = 8'h00;
   localparam logic [7:0] ADDR_FLA_HI  = 8'h04;
   localparam logic [7:0] ADDR_CTRL    = 8'h08;
   localparam logic [7:0] ADDR_STATUS  = 8'h0C;
   localparam logic [7:0] ADDR_FPU_IP  = 8'h10;
   // ctrl field positions
   localparam int CTRL_NE   = 0;
   localparam int CTRL_AM   = 1;
   localparam int CTRL_MCE  = 2;
   localparam int CTRL_OSXF = 3;
   localparam int CTRL_PSE  = 4;
   localparam int CTRL_PAE  = 5;
   localparam int CTRL_LONG = 6;
   localparam int CTRL_W    = 7;
   localparam logic [6:0] CTRL_RESET = 7'h00;
   // page-fault error code bits
   localparam int PFE_P   = 0;
   localparam int PFE_RW  = 1;
   localparam int PFE_US  = 2;
   localparam int PFE_RSV = 3;
   localparam int PFE_ID  = 4;
   localparam int PFE_PK  = 5;
   // alignment data types
   localparam logic [3:0] DT_NONE   = 4'h0;
   localparam logic [3:0] DT_WORD   = 4'h1;
   localparam logic [3:0] DT_DWORD  = 4'h2;
   localparam logic [3:0] DT_QWORD  = 4'h3;
   localparam logic [3:0] DT_BITSTR = 4'h4;
   localparam logic [3:0] DT_M256   = 4'h5;
   localparam logic [3:0] DT_M128   = 4'h6;
   localparam logic [3:0] DT_M64    = 4'h7;
   localparam logic [3:0] DT_SEL    = 4'h8;
   localparam logic [3:0] DT_NEAR32 = 4'h9;
   localparam logic [3:0] DT_FAR32  = 4'hA;
   localparam logic [3:0] DT_FAR48  = 4'hB;
   localparam logic [3:0] MAX_INSN_LEN = 4'hF;
   localparam logic [1:0] CPL_USER = 2'h3;
   localparam logic [31:0] BUS_OKAY = 32'h0;
endpackage : fault_pkg

//--- tb/dispatch_model.sv
// dispatch-side stand-in: accepts every exception request and counts it
// assumes requests are one-cycle pulses on mclk_i with no ready handshake
`timescale 1ns/1ns
module dispatch_model (
   input  wire logic        mclk_i,
   input  wire logic        rst_n_i,
   input  wire logic        valid_i,
   output logic      [15:0] count_o
);
   // =====================================
   // request counter
   logic [15:0] count_r;
   // no back-pressure exists, so a lost pulse only shows up in this count
   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         count_r <= 16'h0000;
      end else if (valid_i) begin
         count_r <= count_r + 16'h0001;
      end
   end
   assign count_o = count_r;
endmodule : dispatch_model

//--- tb/testbench.sv
// self-checking bench for the fault detector, random stimulus with corner cases
// assumes fault_pkg, the design and dispatch_model are compiled first
`timescale 1ns/1ns
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin bad_count++; \
   $display("[ERR] t=%0t got=%0h exp=%0h", $time, (g), (e)); end end
module testbench;
   logic        mclk_i, rst_n_i, awv, wv, bry, arv, rry, acf, pfw, ipv;
   logic [7:0]  awa, ara;
   logic [31:0] wd, rd;
   logic [25:0] p, ex;
   logic [3:0]  ws;
   logic [1:0]  current_privilege_level, os;
   logic [63:0] ip, la, lip;
   logic [15:0] sel;
   logic [5:0]  xs, xm, ss, sm;
   logic [3:0]  dt, alo;
   wire         awr, wr_r, bv, arr, rv, ev, ecv, ip_valid_flag;
   wire  [1:0]  br, rr;
   wire  [31:0] rdat, ec;
   wire  [7:0]  evec;
   wire  [63:0] eip;
   wire  [15:0] nreq;
   int          bad_count, total_checks, seed, i, j, o, nexp;
   fault_condition_detector uut (.mclk_i(mclk_i), .rst_n_i(rst_n_i),
      .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd),
      .s_axi_wstrb(ws), .s_axi_wvalid(wv), .s_axi_wready(wr_r), .s_axi_bresp(br),
      .s_axi_bvalid(bv), .s_axi_bready(bry), .s_axi_araddr(ara), .s_axi_arvalid(arv),
      .s_axi_arready(arr), .s_axi_rdata(rdat), .s_axi_rresp(rr), .s_axi_rvalid(rv),
      .s_axi_rready(rry), .current_privilege_level_i(current_privilege_level), .alignment_check_flag_i(acf),
      .insn_ip_i(ip), .seg_priv_fail_i(p[0]), .seg_type_fail_i(p[1]),
      .null_sel_load_i(p[2]), .gate_null_sel_i(p[3]), .gate_bad_long_i(p[4]),
      .task_xfer_long_i(p[5]), .sysdesc_bad_long_i(p[6]), .selector_i(sel),
      .dtr_noncanon_i(p[7]), .insn_len_i(4'h0), .insn_len_over_i(p[8]),
      .fetch_bad_i(p[9]), .msr_write_bad_i(p[10]), .cr_write_bad_i(p[11]),
      .cr_set_nw_i(p[12]), .cr_set_cd_i(p[13]), .priv_insn_i(p[14]),
      .media_unaligned_i(p[15]), .seg_write_bad_i(p[16]), .pf_not_present_i(p[17]),
      .pf_nx_fetch_i(p[18]), .pf_prot_fail_i(p[19]), .pf_rsv_bit_i(p[20]),
      .pf_key_fail_i(p[21]), .pf_write_i(pfw), .pf_linear_addr_i(la),
      .x87_status_i(xs), .x87_mask_i(xm), .x87_wait_insn_i(p[22]), .x87_last_ip_i(lip),
      .data_ref_i(p[23]), .data_type_i(dt), .data_opsize_i(os), .data_addr_lo_i(alo),
      .mc_error_i(p[24]), .ip_valid_flag_i(ipv), .simd_status_i(ss), .simd_mask_i(sm),
      .simd_event_i(p[25]), .exc_valid_o(ev), .exc_vector_o(evec),
      .exc_code_valid_o(ecv), .exc_code_o(ec), .exc_ip_o(eip), .exc_ip_valid_o(ip_valid_flag));
   dispatch_model dm (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .valid_i(ev), .count_o(nreq));
   initial begin
      mclk_i = 1'b0;
      forever #20 mclk_i = ~mclk_i;
   end
   // =====================================
   // tasks
   task automatic end_of_test;
      if (bad_count == 0 && total_checks > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask : end_of_test
   task automatic tmo;
      bad_count++;
      end_of_test();
   endtask : tmo
   // outputs only move at rising edges, so the falling edge sees what the next edge samples
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic ad, dd, bd;
      bd = 1'b0;
      @(posedge mclk_i);
      {awa, wd} <= {a, d};
      {awv, wv, bry} <= 3'b111;
      for (int n = 0; n < 40 && !bd; n++) begin
         @(negedge mclk_i);
         {ad, dd, bd} = {awv & awr, wv & wr_r, bv};
         @(posedge mclk_i);
         {awv, wv, bry} <= {awv & ~ad, wv & ~dd, ~bd};
      end
      if (!bd) tmo();
   endtask : wr
   task automatic rc(input logic [7:0] a, input logic [31:0] e);
      logic ad, dd;
      dd = 1'b0;
      @(posedge mclk_i);
      ara <= a;
      {arv, rry} <= 2'b11;
      for (int n = 0; n < 40 && !dd; n++) begin
         @(negedge mclk_i);
         {ad, dd, rd} = {arv & arr, rv, rdat};
         @(posedge mclk_i);
         {arv, rry} <= {arv & ~ad, ~dd};
      end
      if (!dd) tmo();
      `CHK(rd, e)
   endtask : rc
   task automatic cw(input logic [6:0] v);
      wr(fault_pkg::ADDR_CTRL, {25'h0, v});
   endtask : cw
   task automatic rnd;
      @(posedge mclk_i);
      sel <= 16'($random(seed));
      {ip, la, lip} <= {$random(seed), $random(seed), $random(seed), $random(seed),
                        $random(seed), $random(seed)};
      ipv <= 1'($random(seed));
      @(negedge mclk_i);
   endtask : rnd
   // pulse cause b for one cycle, then look at the registered request
   task automatic shot(input int b, input logic e, input logic [7:0] v, input logic c,
                       input logic [31:0] k);
      @(posedge mclk_i);
      p <= (26'h1 << b) | ex;
      @(posedge mclk_i);
      p <= '0;
      #1;
      `CHK(ev, e)
      if (e) begin
         nexp++;
         `CHK({evec, ecv}, {v, c})
         if (!$isunknown(k)) `CHK(ec, k)
         if (v != fault_pkg::VEC_MC) `CHK(eip, ip)
      end
   endtask : shot
   function automatic int al(input logic [3:0] t, input logic [1:0] s);
      case (t)
         fault_pkg::DT_WORD, fault_pkg::DT_SEL, fault_pkg::DT_FAR32: return 2;
         fault_pkg::DT_DWORD, fault_pkg::DT_NEAR32, fault_pkg::DT_FAR48: return 4;
         fault_pkg::DT_M128, fault_pkg::DT_M256: return 16;
         fault_pkg::DT_BITSTR: return (s == 2'h0) ? 2 : (s == 2'h1) ? 4 : 8;
         default: return 8;
      endcase
   endfunction : al
   // =====================================
   // main sequence
   initial begin
      seed = 32'h23127C02;
      {rst_n_i, awv, wv, bry, arv, rry, p, ex, acf, pfw, ipv, nexp} = '0;
      ws = 4'hF;
      {awa, ara, wd, current_privilege_level, ip, la, lip, sel, xs, xm, ss, sm, dt, alo, os} = '0;
      repeat (5) @(posedge mclk_i);
      rst_n_i <= 1'b1;
      for (i = 0; i < 8; i++) rc(8'(i * 4), 32'h0);
      {current_privilege_level, acf, dt, alo} <= {2'h3, 1'b1, fault_pkg::DT_WORD, 4'h1};
      shot(23, 1'b0, 8'h00, 1'b0, 32'h0);
      cw(7'h40);
      for (i = 0; i < 17; i++) begin
         rnd();
         shot(i, i != 13, fault_pkg::VEC_GP, 1'b1,
              (i < 7) ? {16'h0, sel[15:3], 3'h0} : 32'h0);
      end
      cw(7'h00);
      for (i = 4; i < 8; i++) shot(i, 1'b0, 8'h00, 1'b0, 32'h0);
      current_privilege_level = 2'h0;
      shot(14, 1'b0, 8'h00, 1'b0, 32'h0);
      ex = 26'h3000;
      shot(26, 1'b0, 8'h00, 1'b0, 32'h0);
      ex = '0;
      {current_privilege_level, pfw} = {2'h3, 1'b1};
      for (o = 0; o < 2; o++) begin
         cw(o ? 7'h40 : 7'h00);
         rnd();
         shot(17, 1'b1, fault_pkg::VEC_PF, 1'b1, 32'h6);
         rc(fault_pkg::ADDR_FLA_LO, la[31:0]);
         rc(fault_pkg::ADDR_FLA_HI, o ? la[63:32] : 32'h0);
         ws <= 4'h3;
         wr(fault_pkg::ADDR_FLA_HI, 32'hA5C3_0F1E);
         ws <= 4'hF;
         rc(fault_pkg::ADDR_FLA_HI, o ? {la[63:48], 16'h0F1E} : 32'h0);
      end
      shot(20, 1'b0, 8'h00, 1'b0, 32'h0);
      for (i = 0; i < 2; i++) begin
         cw(i ? 7'h20 : 7'h10);
         for (j = 18; j < 22; j++)
            shot(j, 1'b1, fault_pkg::VEC_PF, 1'b1,
                 {26'h0, j == 21, j == 18, j == 20, 3'h7});
      end
      cw(7'h01);
      for (i = 0; i < 6; i++) begin
         {xs, xm} = {6'h1 << i, ~(6'h1 << i)};
         shot(26, 1'b0, 8'h00, 1'b0, 32'h0);
         shot(22, 1'b1, fault_pkg::VEC_MF, 1'b0, 32'h0);
         xm = 6'h3F;
         shot(22, 1'b0, 8'h00, 1'b0, 32'h0);
      end
      rc(fault_pkg::ADDR_FPU_IP, lip[31:0]);
      cw(7'h00);
      xm <= 6'h00;
      shot(22, 1'b0, 8'h00, 1'b0, 32'h0);
      xs = 6'h00;
      cw(7'h02);
      for (j = 1; j < 12; j++) begin
         for (i = 0; i < 16; i++) begin
            @(posedge mclk_i);
            {dt, alo, os} <= {4'(j), 4'(i), 2'($random(seed))};
            @(negedge mclk_i);
            shot(23, (alo % al(dt, os)) != 0, fault_pkg::VEC_AC, 1'b1, 32'h0);
         end
      end
      {dt, alo, current_privilege_level} = {fault_pkg::DT_DWORD, 4'h2, 2'h2};
      shot(23, 1'b0, 8'h00, 1'b0, 32'h0);
      {current_privilege_level, acf} = {2'h3, 1'b0};
      shot(23, 1'b0, 8'h00, 1'b0, 32'h0);
      shot(24, 1'b0, 8'h00, 1'b0, 32'h0);
      cw(7'h04);
      rnd();
      shot(24, 1'b1, fault_pkg::VEC_MC, 1'b0, 32'h0);
      `CHK(ip_valid_flag, ipv)
      ex = 26'h1;
      shot(24, 1'b1, fault_pkg::VEC_MC, 1'b0, 32'h0);
      ex = '0;
      for (o = 0; o < 2; o++) begin
         cw(o ? 7'h08 : 7'h00);
         for (i = 0; i < 6; i++) begin
            {ss, sm} <= {6'h1 << i, ~(6'h1 << i)};
            shot(25, 1'b1, o ? fault_pkg::VEC_XF : fault_pkg::VEC_UD, 1'b0, 32'h0);
            sm = 6'h3F;
            shot(25, 1'b0, 8'h00, 1'b0, 32'h0);
         end
      end
      `CHK(nreq, 16'(nexp))
      end_of_test();
   end
endmodule : testbench
